// ---- core/eslr_pkg.sv ----
package eslr_pkg;
   // ****************************************************************
   // register word indices (printed offsets are not all multiples of
   // four, so each printed offset is an index and the word sits at 4x)
   // ****************************************************************
   localparam logic [7:0] IDX_SENSE_POS   = 8'h0f;
   localparam logic [7:0] IDX_SENSE_NEG   = 8'h10;
   localparam logic [7:0] IDX_FLIP        = 8'h11;
   localparam logic [7:0] IDX_STAT_POS    = 8'h12;
   localparam logic [7:0] IDX_STAT_NEG    = 8'h13;
   localparam logic [7:0] IDX_GPIO        = 8'h14;
   localparam logic [7:0] IDX_PACE        = 8'h15;
   localparam logic [7:0] IDX_RSVD        = 8'h16;
   localparam logic [7:0] IDX_CONFIG      = 8'h17;
   localparam logic [7:0] IDX_IRQ_STATUS  = 8'h18;
   localparam logic [7:0] IDX_IRQ_MASK    = 8'h19;
   localparam int         ADDR_W          = 10;

   // ****************************************************************
   // field positions and widths
   // ****************************************************************
   localparam int         NUM_CH          = 8;
   localparam int         IO_PINS         = 4;
   localparam int         IO_DATA_LSB     = 4;
   localparam int         IO_DIR_LSB      = 0;
   localparam int         PACE_EVEN_LSB   = 3;
   localparam int         PACE_ODD_LSB    = 1;
   localparam int         PACE_EN_BIT     = 0;
   localparam int         CFG_SINGLE_BIT  = 3;
   localparam int         CFG_CTB_BIT     = 2;
   localparam int         CFG_COMP_BIT    = 1;
   localparam int         IRQ_W           = 2;
   localparam int         IRQ_POS_BIT     = 0;
   localparam int         IRQ_NEG_BIT     = 1;

   // ****************************************************************
   // reset values and variant masks
   // ****************************************************************
   localparam logic [7:0] RST_ZERO        = 8'h00;
   localparam logic [3:0] RST_IO_DIR      = 4'hf;
   localparam logic [7:0] MASK_CH4        = 8'h0f;
   localparam logic [7:0] MASK_CH6        = 8'h3f;
   localparam logic [7:0] MASK_CH8        = 8'hff;
   localparam logic [1:0] RESP_OKAY       = 2'b00;
   localparam logic [1:0] RESP_SLVERR     = 2'b10;
endpackage

// ---- core/eslr_regs.sv ----
`timescale 1ns/10ps
// How it works
// - positive lead-off sense enables at 0Fh
// - negative lead-off sense enables at 10h
// - variant hides channels 5-8 or 7-8
// - current flip bits per channel at 11h
// - read-only positive lead-off status at 12h
// - read-only negative lead-off status at 13h
// - io data bits read live pin levels
// - data write drives only output pins
// - low nibble sets direction, 1=input default
// - bits 4:3 pick even channel for output two
// - bits 2:1 pick odd channel for output one
// - bit 0 enables spike buffer, default off
// - config bit 3 selects single-shot conversion
// - config bit 2 links terminal to bias
// - config bit 1 enables lead-off comparators
module eslr_regs
   import eslr_pkg::*;
#(
   parameter int CHANNELS = 8
) (
   // clock and reset
   input  wire logic                sys_clk,
   input  wire logic                sys_rst,
   // axi4-lite write address
   input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   // axi4-lite write response
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   // axi4-lite read address
   input  wire logic [ADDR_W-1:0]   s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   // axi4-lite read data
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   // lead-off detection analog side
   input  wire logic [NUM_CH-1:0]   lead_off_pos_in,
   input  wire logic [NUM_CH-1:0]   lead_off_neg_in,
   output logic [NUM_CH-1:0]        lead_off_sense_pos_en,
   output logic [NUM_CH-1:0]        lead_off_sense_neg_en,
   output logic [NUM_CH-1:0]        lead_off_current_flip_en,
   // general-purpose io pins (oe low while driving)
   input  wire logic [IO_PINS-1:0]  io_pin_in,
   output logic [IO_PINS-1:0]       io_pin_out,
   output logic [IO_PINS-1:0]       io_pin_oe_n,
   // spike detect routing
   output logic [1:0]               even_channel_select,
   output logic [1:0]               odd_channel_select,
   output logic                     spike_buffer_enable,
   // conversion and misc config
   output logic                     single_shot_mode,
   output logic                     central_terminal_to_bias_drive,
   output logic                     lead_off_comparator_enable,
   // interrupt
   output logic                     irq
);
   // ****************************************************************
   // helpers
   // ****************************************************************
   // mask of channels this variant implements
   function automatic logic [7:0] chan_mask(input int ch);
      if (ch <= 4)
         return MASK_CH4;
      else if (ch <= 6)
         return MASK_CH6;
      else
         return MASK_CH8;
   endfunction

   // word index of a byte address (address bits 9:2)
   function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] a);
      return a[ADDR_W-1:2];
   endfunction

   localparam logic [7:0] CMASK = chan_mask(CHANNELS);

   // ****************************************************************
   // state
   // ****************************************************************
   logic [7:0]          sense_pos;
   logic [7:0]          sense_neg;
   logic [7:0]          flip;
   logic [IO_PINS-1:0]  io_data;
   logic [IO_PINS-1:0]  io_dir;
   logic [1:0]          pace_even;
   logic [1:0]          pace_odd;
   logic                pace_en;
   logic                cfg_single;
   logic                cfg_ctb;
   logic                cfg_comp;
   logic [IRQ_W-1:0]    irq_status;
   logic [IRQ_W-1:0]    irq_mask;
   logic [7:0]          stat_pos;
   logic [7:0]          stat_neg;
   logic [7:0]          stat_pos_q;
   logic [7:0]          stat_neg_q;
   logic [IO_PINS-1:0]  pins_sync;
   logic                aw_held;
   logic                w_held;
   logic [ADDR_W-1:0]   aw_addr;
   logic [31:0]         w_data;
   logic [3:0]          w_strb;
   logic                do_write;
   logic [7:0]          wr_idx;
   logic [7:0]          wr_byte;
   logic                wr_hit;
   logic [7:0]          next_rdata;
   logic                next_rhit;
   logic [IRQ_W-1:0]    irq_event;

   // ****************************************************************
   // input synchronisers
   // ****************************************************************
   eslr_sync #(.W(NUM_CH)) u_sync_pos (
      .sys_clk  (sys_clk),
      .sys_rst  (sys_rst),
      .async_in (lead_off_pos_in),
      .sync_out (stat_pos)
   );

   eslr_sync #(.W(NUM_CH)) u_sync_neg (
      .sys_clk  (sys_clk),
      .sys_rst  (sys_rst),
      .async_in (lead_off_neg_in),
      .sync_out (stat_neg)
   );

   eslr_sync #(.W(IO_PINS)) u_sync_io (
      .sys_clk  (sys_clk),
      .sys_rst  (sys_rst),
      .async_in (io_pin_in),
      .sync_out (pins_sync)
   );

   // ****************************************************************
   // write channel: address and data taken in either order
   // ****************************************************************
   assign do_write = aw_held && w_held && !s_axi_bvalid;
   assign wr_idx   = word_index(aw_addr);
   assign wr_byte  = w_data[7:0];
   // only the low lane carries register bits; upper lanes are ignored
   assign wr_hit   = do_write && w_strb[0];

   // accept address, hold until the response is issued
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         aw_held       <= 1'b0;
         aw_addr       <= '0;
         s_axi_awready <= 1'b0;
      end else begin
         s_axi_awready <= 1'b0;
         if (s_axi_awvalid && !aw_held && !s_axi_awready) begin
            aw_held       <= 1'b1;
            aw_addr       <= s_axi_awaddr;
            s_axi_awready <= 1'b1;
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
      end
   end

   // accept data, hold until the response is issued
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         w_held       <= 1'b0;
         w_data       <= '0;
         w_strb       <= '0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_wready <= 1'b0;
         if (s_axi_wvalid && !w_held && !s_axi_wready) begin
            w_held       <= 1'b1;
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
            s_axi_wready <= 1'b1;
         end else if (do_write) begin
            w_held <= 1'b0;
         end
      end
   end

   // write response; unmapped addresses answer slverr
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (wr_idx >= IDX_SENSE_POS && wr_idx <= IDX_IRQ_MASK) ?
                         RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ****************************************************************
   // control registers
   // ****************************************************************
   // lead-off sense and current direction, absent channels stay zero
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sense_pos <= RST_ZERO;
         sense_neg <= RST_ZERO;
         flip      <= RST_ZERO;
      end else if (wr_hit) begin
         if (wr_idx == IDX_SENSE_POS)
            sense_pos <= wr_byte & CMASK;
         if (wr_idx == IDX_SENSE_NEG)
            sense_neg <= wr_byte & CMASK;
         if (wr_idx == IDX_FLIP)
            flip      <= wr_byte & CMASK;
      end
   end

   // io register: data latched always, only reaches output pins
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         io_data <= '0;
         io_dir  <= RST_IO_DIR;
      end else if (wr_hit && wr_idx == IDX_GPIO) begin
         io_data <= wr_byte[IO_DATA_LSB +: IO_PINS];
         io_dir  <= wr_byte[IO_DIR_LSB +: IO_PINS];
      end
   end

   // spike routing; codes naming absent channels are still stored
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pace_even <= 2'b00;
         pace_odd  <= 2'b00;
         pace_en   <= 1'b0;
      end else if (wr_hit && wr_idx == IDX_PACE) begin
         pace_even <= wr_byte[PACE_EVEN_LSB +: 2];
         pace_odd  <= wr_byte[PACE_ODD_LSB +: 2];
         pace_en   <= wr_byte[PACE_EN_BIT];
      end
   end

   // configuration; bits the host must keep zero are not stored
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfg_single <= 1'b0;
         cfg_ctb    <= 1'b0;
         cfg_comp   <= 1'b0;
      end else if (wr_hit && wr_idx == IDX_CONFIG) begin
         cfg_single <= wr_byte[CFG_SINGLE_BIT];
         cfg_ctb    <= wr_byte[CFG_CTB_BIT];
         cfg_comp   <= wr_byte[CFG_COMP_BIT];
      end
   end

   // ****************************************************************
   // interrupts: a newly detached, sensed electrode sets a sticky bit
   // ****************************************************************
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         stat_pos_q <= RST_ZERO;
         stat_neg_q <= RST_ZERO;
      end else begin
         stat_pos_q <= stat_pos;
         stat_neg_q <= stat_neg;
      end
   end

   // gating by sense enable spares software unsensed noise
   assign irq_event[IRQ_POS_BIT] = |(stat_pos & ~stat_pos_q & sense_pos);
   assign irq_event[IRQ_NEG_BIT] = |(stat_neg & ~stat_neg_q & sense_neg);

   // write one to clear; a same-cycle event wins over the clear
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_status <= '0;
         irq_mask   <= '0;
      end else begin
         if (wr_hit && wr_idx == IDX_IRQ_STATUS)
            irq_status <= (irq_status & ~wr_byte[IRQ_W-1:0]) | irq_event;
         else
            irq_status <= irq_status | irq_event;
         if (wr_hit && wr_idx == IDX_IRQ_MASK)
            irq_mask <= wr_byte[IRQ_W-1:0];
      end
   end

   // ****************************************************************
   // read channel
   // ****************************************************************
   // read decode; lead-off status registers are live and writes never touch them
   always_comb begin
      next_rdata = 8'h00;
      next_rhit  = 1'b1;
      case (word_index(s_axi_araddr))
         IDX_SENSE_POS:  next_rdata = sense_pos;
         IDX_SENSE_NEG:  next_rdata = sense_neg;
         IDX_FLIP:       next_rdata = flip;
         IDX_STAT_POS:   next_rdata = stat_pos & CMASK;
         IDX_STAT_NEG:   next_rdata = stat_neg & CMASK;
         IDX_GPIO:       next_rdata = {pins_sync, io_dir};
         IDX_PACE:       next_rdata = {3'b000, pace_even, pace_odd, pace_en};
         IDX_RSVD:       next_rdata = 8'h00;
         IDX_CONFIG:     next_rdata = {4'h0, cfg_single, cfg_ctb, cfg_comp, 1'b0};
         IDX_IRQ_STATUS: next_rdata = {6'h00, irq_status};
         IDX_IRQ_MASK:   next_rdata = {6'h00, irq_mask};
         default:        next_rhit  = 1'b0;
      endcase
   end

   // one read at a time; address taken and data registered on the same edge
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= 1'b0;
         if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h000000, next_rdata};
            s_axi_rresp   <= next_rhit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // registered outputs
   // ****************************************************************
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         lead_off_sense_pos_en          <= '0;
         lead_off_sense_neg_en          <= '0;
         lead_off_current_flip_en       <= '0;
         io_pin_out                     <= '0;
         io_pin_oe_n                    <= '1;
         even_channel_select            <= 2'b00;
         odd_channel_select             <= 2'b00;
         spike_buffer_enable            <= 1'b0;
         single_shot_mode               <= 1'b0;
         central_terminal_to_bias_drive <= 1'b0;
         lead_off_comparator_enable     <= 1'b0;
         irq                            <= 1'b0;
      end else begin
         lead_off_sense_pos_en          <= sense_pos;
         lead_off_sense_neg_en          <= sense_neg;
         lead_off_current_flip_en       <= flip;
         io_pin_out                     <= io_data;
         io_pin_oe_n                    <= io_dir;
         even_channel_select            <= pace_even;
         odd_channel_select             <= pace_odd;
         spike_buffer_enable            <= pace_en;
         single_shot_mode               <= cfg_single;
         central_terminal_to_bias_drive <= cfg_ctb;
         lead_off_comparator_enable     <= cfg_comp;
         irq                            <= |(irq_status & irq_mask);
      end
   end
endmodule

// ---- core/eslr_sync.sv ----
`timescale 1ns/10ps
// two-flop synchroniser for a bus of asynchronous levels
module eslr_sync #(
   parameter int W = 8
) (
   // clock and reset
   input  wire logic         sys_clk,
   input  wire logic         sys_rst,
   // levels
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] stage_one;

   // first stage feeds only the second stage
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         stage_one <= '0;
         sync_out  <= '0;
      end else begin
         stage_one <= async_in;
         sync_out  <= stage_one;
      end
   end
endmodule

// ---- test/electrode_status_gpio_pace_config_regs_tb.sv ----
`timescale 1ns/10ps
module electrode_status_gpio_pace_config_regs_tb;
   import eslr_pkg::*;
   logic        sys_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [9:0]  awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, d;
   logic [3:0]  wstrb = 4'h1;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic        awready, wready, bvalid, arready, rvalid, sbe, ssm, ctb, lce, irq;
   logic [1:0]  bresp, rresp, evs, ods, r;
   logic [7:0]  pos_in = 8'h00, neg_in = 8'h00, spe, sne, flp, v;
   logic [3:0]  ext = 4'h6, pin, pout, poe_n;
   int          miscompares = 0, checks_done = 0;

   // pin level: driven by the block where enabled, else by the outside
   assign pin = (pout & ~poe_n) | (ext & poe_n);
   always #12.5 sys_clk = ~sys_clk;

   eslr_regs dut (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .lead_off_pos_in(pos_in), .lead_off_neg_in(neg_in), .lead_off_sense_pos_en(spe),
      .lead_off_sense_neg_en(sne), .lead_off_current_flip_en(flp), .io_pin_in(pin),
      .io_pin_out(pout), .io_pin_oe_n(poe_n), .even_channel_select(evs),
      .odd_channel_select(ods), .spike_buffer_enable(sbe), .single_shot_mode(ssm),
      .central_terminal_to_bias_drive(ctb), .lead_off_comparator_enable(lce), .irq(irq));

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         $display("Error %s expected %h seen %h", nm, exp, seen);
         miscompares++;
      end
   endtask

   task automatic print_verdict;
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // late bready makes the response wait a cycle on purpose
   task automatic wr(input logic [7:0] idx, input logic [7:0] val, output logic [1:0] rs);
      int n;
      @(posedge sys_clk);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h0, val};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge sys_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid && bready) break;
         if (n == 2) bready <= 1'b1;
      end
      rs = bresp;
      bready <= 1'b0;
      if (n == 40) begin
         miscompares++;
         print_verdict;
      end
   endtask

   task automatic rd(input logic [7:0] idx, output logic [31:0] dt, output logic [1:0] rs);
      int n;
      @(posedge sys_clk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge sys_clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid && rready) break;
         if (n == 1) rready <= 1'b1;
      end
      dt = rdata;
      rs = rresp;
      rready <= 1'b0;
      if (n == 40) begin
         miscompares++;
         print_verdict;
      end
   endtask

   // register copies follow one cycle after the response
   task automatic w2;
      repeat (2) @(posedge sys_clk);
   endtask

   task automatic t_reset;
      check("oe_n", poe_n, 4'hf);
      check("flags", {sbe, ssm, ctb, lce}, 4'h0);
      rd(IDX_GPIO, d, r);
      check("gpio", d, 32'h6f);
      rd(IDX_PACE, d, r);
      check("pace", d, 32'h0);
      rd(IDX_CONFIG, d, r);
      check("config", d, 32'h0);
      $display("t_reset done");
   endtask

   task automatic t_rw;
      logic [7:0] ix[3] = '{IDX_SENSE_POS, IDX_SENSE_NEG, IDX_FLIP};
      logic [7:0] vl[3] = '{8'h5a, 8'hc3, 8'h81};
      for (int i = 0; i < 3; i++) begin
         wr(ix[i], vl[i], r);
         rd(ix[i], d, r);
         check("readback", d, {24'h0, vl[i]});
      end
      w2;
      check("sense_pos", spe, 8'h5a);
      check("sense_neg", sne, 8'hc3);
      check("flip", flp, 8'h81);
      $display("t_rw done");
   endtask

   task automatic t_status;
      pos_in <= 8'h96;
      neg_in <= 8'h69;
      repeat (4) @(posedge sys_clk);
      rd(IDX_STAT_POS, d, r);
      check("stat_pos", d, 32'h96);
      rd(IDX_STAT_NEG, d, r);
      check("stat_neg", d, 32'h69);
      wr(IDX_STAT_POS, 8'hff, r);
      rd(IDX_STAT_POS, d, r);
      check("stat_ro", d, 32'h96);
      $display("t_status done");
   endtask

   task automatic t_gpio;
      wr(IDX_GPIO, 8'ha3, r);
      w2;
      check("oe_n", poe_n, 4'h3);
      check("drive", pout & ~poe_n, 4'h8);
      w2;
      rd(IDX_GPIO, d, r);
      check("gpio_out", d, 32'ha3);
      wr(IDX_GPIO, 8'h5f, r);
      w2;
      check("drive_in", pout & ~poe_n, 4'h0);
      w2;
      rd(IDX_GPIO, d, r);
      check("gpio_in", d, 32'h6f);
      $display("t_gpio done");
   endtask

   task automatic t_pace_cfg;
      for (int i = 0; i < 16; i++) begin
         v = {3'b000, i[3:0], i[0]};
         wr(IDX_PACE, v, r);
         w2;
         check("route", {evs, ods, sbe}, v[4:0]);
      end
      for (int k = 0; k < 3; k++) begin
         v = 8'h08 >> k;
         wr(IDX_CONFIG, v, r);
         w2;
         check("cfg", {ssm, ctb, lce}, v[3:1]);
         rd(IDX_CONFIG, d, r);
         check("cfg_rd", d, {24'h0, v});
      end
      $display("t_pace_cfg done");
   endtask

   task automatic t_unmapped;
      wr(8'h00, 8'h55, r);
      check("bresp", r, RESP_SLVERR);
      rd(8'hfc, d, r);
      check("rresp", r, RESP_SLVERR);
      check("rdata", d, 32'h0);
      // a write with the low lane disabled must leave the register alone
      wstrb <= 4'h0;
      wr(IDX_SENSE_POS, 8'hff, r);
      wstrb <= 4'h1;
      check("strb_resp", r, RESP_OKAY);
      rd(IDX_SENSE_POS, d, r);
      check("no_strb", d, 32'h5a);
      $display("t_unmapped done");
   endtask

   // a detach on a sensed channel raises the interrupt
   task automatic t_irq;
      // earlier status scenario left both sticky bits set
      wr(IDX_IRQ_STATUS, 8'h03, r);
      wr(IDX_SENSE_POS, 8'h01, r);
      wr(IDX_IRQ_MASK, 8'h01, r);
      pos_in <= 8'h97;
      repeat (6) @(posedge sys_clk);
      check("irq_set", irq, 1'b1);
      rd(IDX_IRQ_STATUS, d, r);
      check("irq_stat", d, 32'h1);
      wr(IDX_IRQ_MASK, 8'h00, r);
      w2;
      check("irq_mask", irq, 1'b0);
      wr(IDX_IRQ_MASK, 8'h01, r);
      w2;
      check("irq_unmask", irq, 1'b1);
      wr(IDX_IRQ_STATUS, 8'h01, r);
      w2;
      check("irq_clr", irq, 1'b0);
      $display("t_irq done");
   endtask

   initial begin
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      t_reset;
      t_rw;
      t_status;
      t_gpio;
      t_pace_cfg;
      t_unmapped;
      t_irq;
      print_verdict;
   end
endmodule

// ---- test/eslr_regs_props.sv ----
`timescale 1ns/10ps
module eslr_regs_props
   import eslr_pkg::*;
#(
   parameter int CHANNELS = 8
) (
   // clock and reset
   input wire logic              sys_clk,
   input wire logic              sys_rst,
   // bus
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic              s_axi_awvalid,
   input wire logic              s_axi_awready,
   input wire logic [31:0]       s_axi_wdata,
   input wire logic [3:0]        s_axi_wstrb,
   input wire logic              s_axi_wvalid,
   input wire logic              s_axi_wready,
   input wire logic [1:0]        s_axi_bresp,
   input wire logic              s_axi_bvalid,
   input wire logic              s_axi_bready,
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic [31:0]       s_axi_rdata,
   input wire logic [1:0]        s_axi_rresp,
   input wire logic              s_axi_rvalid,
   input wire logic              s_axi_rready,
   // register copies
   input wire logic [NUM_CH-1:0] lead_off_sense_pos_en,
   input wire logic [IO_PINS-1:0] io_pin_oe_n,
   input wire logic [1:0]        even_channel_select,
   input wire logic [1:0]        odd_channel_select,
   input wire logic              spike_buffer_enable
);
   // channels a smaller variant lacks must never show up
   localparam logic [7:0] CHM = (CHANNELS == 4) ? MASK_CH4 :
                                (CHANNELS == 6) ? MASK_CH6 : MASK_CH8;
   logic [ADDR_W-1:0] wa;
   logic [7:0]        wd;
   logic              ws;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   // remember the accepted write, address and data land separately
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wa <= '0;
         wd <= 8'h00;
         ws <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready) begin
            wd <= s_axi_wdata[7:0];
            ws <= s_axi_wstrb[0];
         end
      end
   end

   chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped early");
   chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped early");
   chk_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready
      |=> s_axi_arready && s_axi_rvalid) else $error("read not answered");
   chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("read upper bits set");
   chk_sense_write: assert property ($rose(s_axi_bvalid) && ws && wa == {IDX_SENSE_POS, 2'b00}
      |=> lead_off_sense_pos_en == (wd & CHM)) else $error("sense enables wrong");
   chk_pace_write: assert property ($rose(s_axi_bvalid) && ws && wa == {IDX_PACE, 2'b00}
      |=> {even_channel_select, odd_channel_select, spike_buffer_enable} == wd[4:0])
      else $error("spike routing wrong");
   chk_dir_write: assert property ($rose(s_axi_bvalid) && ws && wa == {IDX_GPIO, 2'b00}
      |=> io_pin_oe_n == wd[3:0]) else $error("pin direction wrong");
   chk_variant_mask: assert property ((lead_off_sense_pos_en & ~CHM) == 8'h00)
      else $error("absent channel enabled");
   chk_unmapped_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR
      |-> s_axi_rdata == 32'h0) else $error("unmapped read not zero");

   cover property ($rose(s_axi_bvalid) && s_axi_bresp == RESP_SLVERR);
   cover property (s_axi_rvalid && !s_axi_rready);
   cover property ($rose(spike_buffer_enable));
endmodule

bind eslr_regs eslr_regs_props #(.CHANNELS(CHANNELS)) u_props (
   .sys_clk(sys_clk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .lead_off_sense_pos_en(lead_off_sense_pos_en), .io_pin_oe_n(io_pin_oe_n),
   .even_channel_select(even_channel_select), .odd_channel_select(odd_channel_select),
   .spike_buffer_enable(spike_buffer_enable));
